// file: core/ebls_defines.svh
// Constants for the endian byte lane swapper.
// Assumes inclusion by bare name from files under core/.
`ifndef EBLS_DEFINES_SVH
`define EBLS_DEFINES_SVH
// Byte lane bit positions on highway and PCI.
`define EBLS_LANE3_HI 31
`define EBLS_LANE3_LO 24
`define EBLS_LANE2_HI 23
`define EBLS_LANE2_LO 16
`define EBLS_LANE1_HI 15
`define EBLS_LANE1_LO 8
`define EBLS_LANE0_HI 7
`define EBLS_LANE0_LO 0
// Byte order select value meaning little endian.
`define EBLS_ORDER_LITTLE 1'h1
// Bridge control register offset and swap-enable field.
`define EBLS_BRIDGE_CTL_OFS 12'h000
`define EBLS_SE_BIT 0
`define EBLS_SE_RESET 1'h0
// Output FIFO size.
`define EBLS_FIFO_DEPTH 16
`define EBLS_DATA_W 32
`endif

// file: core/ebls_pkg.sv
// Types shared by the endian byte lane swapper modules.
// Assumes nothing outside this package.
package ebls_pkg;
    // Access size of a data cache transfer.
    typedef enum logic [1:0] {
        EBLS_SZ_BYTE = 2'h0,
        EBLS_SZ_HALF = 2'h1,
        EBLS_SZ_WORD = 2'h2
    } ebls_size_e;
    // Target class of a data cache transfer.
    typedef enum logic [1:0] {
        EBLS_K_MEM = 2'h0,
        EBLS_K_REG = 2'h1,
        EBLS_K_WIN = 2'h2
    } ebls_kind_e;
    // Pixel formats handled by the image coprocessor path.
    typedef enum logic [2:0] {
        EBLS_PX_PLANAR = 3'h0,
        EBLS_PX_RGB8 = 3'h1,
        EBLS_PX_RGB24A = 3'h2,
        EBLS_PX_RGB15A = 3'h3,
        EBLS_PX_RGB16 = 3'h4,
        EBLS_PX_YUV422 = 3'h5,
        EBLS_PX_RGB24 = 3'h6
    } ebls_pixel_e;
    typedef logic [31:0] ebls_word_t;
endpackage

// file: core/ebls_fifo_if.sv
// Carrier between the swapper core and its output FIFO.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface ebls_fifo_if #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic [$clog2(DEPTH+1)-1:0] level;
    // Producer and consumer side seen by the core.
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data, level);
    // The FIFO itself.
    modport store (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data, level);
endinterface
`default_nettype wire

// file: core/ebls_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes a single clock and an active high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ebls_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Both sides.
    ebls_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic do_push;
    logic do_pop;

    // Full and empty come straight from the occupancy count.
    assign f.push_ready = (cnt_q != (AW+1)'(DEPTH));
    assign f.pop_valid = (cnt_q != '0);
    assign f.pop_data = mem_q[rd_q];
    assign f.level = cnt_q;
    assign do_push = f.push_valid && f.push_ready;
    assign do_pop = f.pop_valid && f.pop_ready;

    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_q] <= f.push_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
        end
    end

    // Occupancy count.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (do_push && !do_pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (do_pop && !do_push) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: core/ebls_swapper.sv
// Byte order handling of the media processor: data cache lane
// steering, bridge register swapping, instruction pass and the
// image coprocessor pixel stream with its output FIFO.
// Assumes all inputs come from logic on CLK; nothing is synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "ebls_defines.svh"

// What this block does
// - Lane 3 is bits 31:24 down to lane 0 at bits 7:0.
// - Byte at offset n always travels on lane n, any mode.
// - Byte order select 1 means little endian, 0 big endian.
// - Big endian reverses word bytes; halves swap in their lane pair.
// - Memory translation only inside memory base to limit window.
// - Register accesses from the processor are never swapped.
// - Data window register gets the memory translation anyway.
// - Bridge moves window and special register data unswapped.
// - Instruction fetch is always little endian, ignores select.
// - PCI to SDRAM data passes unswapped in both modes.
// - Swap enable 0 swaps PCI register data; 1 does not.
// - Swap enable resets to 0; its own write is swapped.
// - Coprocessor keeps pixel data consistent in both modes.
// - 8-bit indexed and planar formats pass as byte streams.
// - 24+alpha, 15+alpha, 16 and YUV 4:2:2 work in both modes.
// - Packed 24-bit RGB is refused in big endian mode.
// - Planar samples sit on lane n modulo 4 in both modes.
// - Little endian data cache never reorders bytes.
// - Coprocessor input swap only in big endian mode.
module ebls_swapper
    import ebls_pkg::*;
#(
    parameter int WIDTH = `EBLS_DATA_W,
    parameter int DEPTH = `EBLS_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Configuration.
    input wire logic BYTE_ORDER_SELECT,
    input wire logic [31:0] MEM_BASE,
    input wire logic [31:0] MEM_LIMIT,
    // Data cache request.
    input wire logic DC_VALID,
    input wire logic DC_WRITE,
    input wire logic [1:0] DC_SIZE,
    input wire logic [1:0] DC_KIND,
    input wire logic [31:0] DC_ADDR,
    input wire logic [31:0] DC_REG_WDATA,
    input wire logic [31:0] DC_BUS_RDATA,
    // Data cache answer.
    output logic DC_DONE,
    output logic [31:0] DC_BUS_WDATA,
    output logic [3:0] DC_BUS_BE,
    output logic [31:0] DC_REG_RDATA,
    // Bridge register access from PCI or the processor.
    input wire logic BR_VALID,
    input wire logic BR_WRITE,
    input wire logic BR_FROM_PCI,
    input wire logic BR_IS_REG,
    input wire logic BR_IS_SPECIAL,
    input wire logic [11:0] BR_ADDR,
    input wire logic [31:0] BR_WDATA,
    input wire logic [31:0] BR_RDATA,
    // Bridge answer.
    output logic BR_DONE,
    output logic [31:0] BR_WDATA_OUT,
    output logic [31:0] BR_RDATA_OUT,
    output logic BRIDGE_SWAP_ENABLE,
    // Instruction fetch.
    input wire logic IC_VALID,
    input wire logic [31:0] IC_BUS_DATA,
    output logic IC_DONE,
    output logic [31:0] IC_INSTR,
    // Coprocessor pixel stream in.
    input wire logic ICP_IN_VALID,
    input wire logic [WIDTH-1:0] ICP_IN_DATA,
    input wire logic [2:0] ICP_FORMAT,
    output logic ICP_IN_READY,
    output logic ICP_FMT_ERROR,
    // Coprocessor pixel stream out.
    output logic ICP_OUT_VALID,
    output logic [WIDTH-1:0] ICP_OUT_DATA,
    input wire logic ICP_OUT_READY
);
    // Full reversal of the four lanes.
    function automatic ebls_word_t bsw(input ebls_word_t w);
        bsw = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // Byte swap inside each half word.
    function automatic ebls_word_t bsh(input ebls_word_t w);
        bsh = {w[23:16], w[31:24], w[7:0], w[15:8]};
    endfunction

    logic little;
    logic in_win;
    logic xlate;
    logic [1:0] off;
    logic [3:0] be_d;
    logic [31:0] wbus_d;
    logic [31:0] rreg_d;
    logic [15:0] half_r;
    logic [15:0] half_w;
    logic [7:0] byte_r;

    // Select 1 is little endian.
    assign little = (BYTE_ORDER_SELECT == `EBLS_ORDER_LITTLE);
    assign off = DC_ADDR[1:0];
    // Translation window is inclusive of base, exclusive of limit.
    assign in_win = (DC_ADDR >= MEM_BASE) && (DC_ADDR < MEM_LIMIT);
    // Plain registers skip translation; the data window never does.
    assign xlate = (ebls_kind_e'(DC_KIND) == EBLS_K_WIN) ||
                   ((ebls_kind_e'(DC_KIND) == EBLS_K_MEM) && in_win);

    // Store side: place register data on the lanes of its offset.
    always_comb begin
        wbus_d = '0;
        be_d = '0;
        half_w = '0;
        case (ebls_size_e'(DC_SIZE))
            EBLS_SZ_WORD: begin
                be_d = 4'hF;
                // Big endian reverses all four lanes.
                wbus_d = (xlate && !little) ? bsw(DC_REG_WDATA)
                                            : DC_REG_WDATA;
            end
            EBLS_SZ_HALF: begin
                be_d = off[1] ? 4'hC : 4'h3;
                half_w = (xlate && !little) ?
                    {DC_REG_WDATA[7:0], DC_REG_WDATA[15:8]} :
                    DC_REG_WDATA[15:0];
                wbus_d = off[1] ? {half_w, 16'h0000}
                                : {16'h0000, half_w};
            end
            EBLS_SZ_BYTE: begin
                // Bytes always sit on the lane of their offset.
                be_d = 4'h1 << off;
                wbus_d = {4{DC_REG_WDATA[7:0]}} & {{8{be_d[3]}},
                    {8{be_d[2]}}, {8{be_d[1]}}, {8{be_d[0]}}};
            end
            default: begin
                be_d = '0;
                wbus_d = '0;
            end
        endcase
    end

    // Load side: collect the lanes and undo the translation.
    always_comb begin
        rreg_d = '0;
        half_r = '0;
        byte_r = '0;
        case (ebls_size_e'(DC_SIZE))
            EBLS_SZ_WORD: begin
                rreg_d = (xlate && !little) ? bsw(DC_BUS_RDATA)
                                            : DC_BUS_RDATA;
            end
            EBLS_SZ_HALF: begin
                half_r = off[1] ? DC_BUS_RDATA[31:16]
                                : DC_BUS_RDATA[15:0];
                rreg_d = (xlate && !little) ?
                    {16'h0000, half_r[7:0], half_r[15:8]} :
                    {16'h0000, half_r};
            end
            EBLS_SZ_BYTE: begin
                case (off)
                    2'h0: byte_r = DC_BUS_RDATA[`EBLS_LANE0_HI:`EBLS_LANE0_LO];
                    2'h1: byte_r = DC_BUS_RDATA[`EBLS_LANE1_HI:`EBLS_LANE1_LO];
                    2'h2: byte_r = DC_BUS_RDATA[`EBLS_LANE2_HI:`EBLS_LANE2_LO];
                    default: byte_r =
                        DC_BUS_RDATA[`EBLS_LANE3_HI:`EBLS_LANE3_LO];
                endcase
                rreg_d = {24'h000000, byte_r};
            end
            default: begin
                rreg_d = '0;
            end
        endcase
    end

    // Data cache answers one cycle after the request.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DC_DONE <= 1'b0;
            DC_BUS_WDATA <= '0;
            DC_BUS_BE <= '0;
            DC_REG_RDATA <= '0;
        end else begin
            DC_DONE <= DC_VALID;
            if (DC_VALID) begin
                DC_BUS_WDATA <= DC_WRITE ? wbus_d : '0;
                DC_BUS_BE <= be_d;
                DC_REG_RDATA <= DC_WRITE ? '0 : rreg_d;
            end
        end
    end

    logic br_swap;
    logic [31:0] br_win;

    // Only PCI-side accesses to ordinary registers are swapped, and
    // only while the swap enable is still clear.
    assign br_swap = BR_FROM_PCI && BR_IS_REG && !BR_IS_SPECIAL &&
                     !BRIDGE_SWAP_ENABLE;
    assign br_win = br_swap ? bsw(BR_WDATA) : BR_WDATA;

    // Bridge data path; non-register data passes untouched.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BR_DONE <= 1'b0;
            BR_WDATA_OUT <= '0;
            BR_RDATA_OUT <= '0;
        end else begin
            BR_DONE <= BR_VALID;
            if (BR_VALID) begin
                BR_WDATA_OUT <= BR_WRITE ? br_win : '0;
                BR_RDATA_OUT <= BR_WRITE ? '0 :
                    (br_swap ? bsw(BR_RDATA) : BR_RDATA);
            end
        end
    end

    // The control write is itself seen through the swapper, so a
    // little endian host must pre-swap the value it writes.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BRIDGE_SWAP_ENABLE <= `EBLS_SE_RESET;
        end else if (BR_VALID && BR_WRITE && BR_IS_REG &&
                     (BR_ADDR == `EBLS_BRIDGE_CTL_OFS)) begin
            BRIDGE_SWAP_ENABLE <= br_win[`EBLS_SE_BIT];
        end
    end

    // Instruction words bypass the select bit entirely.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IC_DONE <= 1'b0;
            IC_INSTR <= '0;
        end else begin
            IC_DONE <= IC_VALID;
            if (IC_VALID) begin
                IC_INSTR <= IC_BUS_DATA;
            end
        end
    end

    ebls_fifo_if #(.WIDTH(WIDTH), .DEPTH(DEPTH)) fq ();
    logic px_reject;
    logic [WIDTH-1:0] px_d;
    logic in_take;
    logic out_load;

    ebls_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk(CLK),
        .rst(RST),
        .f(fq.store)
    );

    // Packed 24-bit RGB has no big endian layout, so it is dropped.
    assign px_reject = !little &&
        (ebls_pixel_e'(ICP_FORMAT) == EBLS_PX_RGB24);

    // Input swap per pixel format, big endian only.
    always_comb begin
        px_d = ICP_IN_DATA;
        if (!little) begin
            case (ebls_pixel_e'(ICP_FORMAT))
                EBLS_PX_RGB24A: px_d = bsw(ICP_IN_DATA);
                EBLS_PX_RGB15A: px_d = bsh(ICP_IN_DATA);
                EBLS_PX_RGB16: px_d = bsh(ICP_IN_DATA);
                EBLS_PX_YUV422: px_d = bsh(ICP_IN_DATA);
                EBLS_PX_RGB8: px_d = ICP_IN_DATA;
                EBLS_PX_PLANAR: px_d = ICP_IN_DATA;
                default: px_d = ICP_IN_DATA;
            endcase
        end
    end

    assign in_take = ICP_IN_VALID && ICP_IN_READY;
    assign fq.push_valid = in_take && !px_reject;
    assign fq.push_data = px_d;
    // Output register refills when empty or being drained.
    assign out_load = !ICP_OUT_VALID || ICP_OUT_READY;
    assign fq.pop_ready = out_load;

    // Ready is registered, so it leaves one slot in hand: at most
    // one push can land between the level sample and its use.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ICP_IN_READY <= 1'b0;
        end else begin
            ICP_IN_READY <= (int'(fq.level) < DEPTH - 1);
        end
    end

    // Error flag pulses for each refused word.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ICP_FMT_ERROR <= 1'b0;
        end else begin
            ICP_FMT_ERROR <= in_take && px_reject;
        end
    end

    // Output stage holds a word until the consumer takes it.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ICP_OUT_VALID <= 1'b0;
            ICP_OUT_DATA <= '0;
        end else if (out_load) begin
            ICP_OUT_VALID <= fq.pop_valid;
            if (fq.pop_valid) begin
                ICP_OUT_DATA <= fq.pop_data;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/ebls_swapper_properties.sv
// Port-level checks of the endian byte lane swapper.
// Assumes one clock domain; bound into ebls_swapper below.
`timescale 1ns/1ps
`default_nettype none
module ebls_swapper_properties (
    // Clock, reset, mode.
    input wire logic CLK,
    input wire logic RST,
    input wire logic BYTE_ORDER_SELECT,
    // Data cache.
    input wire logic DC_VALID,
    input wire logic DC_WRITE,
    input wire logic [1:0] DC_SIZE,
    input wire logic [1:0] DC_KIND,
    input wire logic [31:0] DC_ADDR,
    input wire logic [31:0] DC_REG_WDATA,
    input wire logic DC_DONE,
    input wire logic [31:0] DC_BUS_WDATA,
    input wire logic [3:0] DC_BUS_BE,
    // Bridge.
    input wire logic BR_VALID,
    input wire logic BR_WRITE,
    input wire logic BR_FROM_PCI,
    input wire logic BR_IS_REG,
    input wire logic BR_IS_SPECIAL,
    input wire logic [11:0] BR_ADDR,
    input wire logic [31:0] BR_WDATA,
    input wire logic BR_DONE,
    input wire logic [31:0] BR_WDATA_OUT,
    input wire logic BRIDGE_SWAP_ENABLE,
    // Instruction fetch and pixel input.
    input wire logic IC_VALID,
    input wire logic [31:0] IC_BUS_DATA,
    input wire logic IC_DONE,
    input wire logic [31:0] IC_INSTR,
    input wire logic ICP_IN_VALID,
    input wire logic ICP_IN_READY,
    input wire logic [2:0] ICP_FORMAT,
    input wire logic ICP_FMT_ERROR
);
    logic ctl_wr;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Any register write to the control offset may move swap enable.
    assign ctl_wr = BR_VALID && BR_WRITE && BR_IS_REG && BR_ADDR == 12'h000;
    function automatic logic [31:0] bsw(logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction
    sequence s_word_st;
        DC_VALID && DC_WRITE && DC_SIZE == 2'h2;
    endsequence
    sequence s_pci_reg;
        BR_VALID && BR_WRITE && BR_FROM_PCI && BR_IS_REG && !BR_IS_SPECIAL
            && !BRIDGE_SWAP_ENABLE;
    endsequence
    sequence s_bad;
        ICP_IN_VALID && ICP_IN_READY && ICP_FORMAT == 3'h6
            && !BYTE_ORDER_SELECT;
    endsequence
    a_dc_word_lanes: assert property (s_word_st |=> DC_DONE && DC_BUS_BE == 4'hF) else $error("word lanes wrong");
    a_dc_byte_lane: assert property (DC_VALID && DC_SIZE == 2'h0 |=>
        DC_BUS_BE == 4'h1 << $past(DC_ADDR[1:0])) else $error("byte lane wrong");
    a_dc_little_word: assert property (s_word_st ##0 BYTE_ORDER_SELECT |=>
        DC_BUS_WDATA == $past(DC_REG_WDATA)) else $error("little word moved");
    a_dc_reg_plain: assert property (s_word_st ##0 DC_KIND == 2'h1 |=>
        DC_BUS_WDATA == $past(DC_REG_WDATA)) else $error("register swapped");
    a_dc_window_swap: assert property (s_word_st ##0 (DC_KIND == 2'h2 &&
        !BYTE_ORDER_SELECT) |=> DC_BUS_WDATA == bsw($past(DC_REG_WDATA)))
        else $error("window not swapped");
    a_ic_pass_through: assert property (IC_VALID |=> IC_DONE &&
        IC_INSTR == $past(IC_BUS_DATA)) else $error("instruction changed");
    a_se_write_cause: assert property ($rose(BRIDGE_SWAP_ENABLE) |->
        $past(ctl_wr)) else $error("swap enable rose alone");
    a_br_pci_swap: assert property (s_pci_reg |=> BR_DONE &&
        BR_WDATA_OUT == bsw($past(BR_WDATA))) else $error("pci not swapped");
    a_br_cpu_plain: assert property (BR_VALID && BR_WRITE && !BR_FROM_PCI |=>
        BR_WDATA_OUT == $past(BR_WDATA)) else $error("cpu data swapped");
    a_fmt_refused: assert property (s_bad |=> ICP_FMT_ERROR) else $error("packed rgb not refused");
    a_fmt_little_ok: assert property (ICP_IN_VALID && ICP_IN_READY &&
        BYTE_ORDER_SELECT |=> !ICP_FMT_ERROR) else $error("little refused");
endmodule
bind ebls_swapper ebls_swapper_properties i_chk (.*);
`default_nettype wire

// file: dv/ebls_pixel_sink.sv
// Consumer of the pixel output stream, prompt, slow or stalled.
// Assumes pace is changed just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module ebls_pixel_sink (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Pace: 0 prompt, 1 one cycle in four, 2 stalled.
    input wire logic [1:0] pace,
    // Handshake.
    output logic out_ready
);
    logic [1:0] cnt_q;
    // Ready moves only on the edge, so the producer never sees a glitch.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            out_ready <= pace == 2'h0 || (pace == 2'h1 && cnt_q == 2'h3);
        end
    end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench of the endian byte lane swapper.
// Assumes core/ files, the pixel sink and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic CLK = 1'b0, RST = 1'b1, BYTE_ORDER_SELECT = 1'b0;
    logic [31:0] MEM_BASE = 32'h1000, MEM_LIMIT = 32'h2000;
    logic DC_VALID = 1'b0, DC_WRITE = 1'b0, DC_DONE;
    logic [1:0] DC_SIZE = 2'h0, DC_KIND = 2'h0;
    logic [31:0] DC_ADDR = 32'h0, DC_REG_WDATA = 32'h0, DC_BUS_RDATA = 32'h0;
    logic [31:0] DC_BUS_WDATA, DC_REG_RDATA, BR_WDATA_OUT, BR_RDATA_OUT;
    logic [3:0] DC_BUS_BE;
    logic BR_VALID = 1'b0, BR_WRITE = 1'b0, BR_FROM_PCI = 1'b0;
    logic BR_IS_REG = 1'b0, BR_IS_SPECIAL = 1'b0, BR_DONE, BRIDGE_SWAP_ENABLE;
    logic [11:0] BR_ADDR = 12'h000;
    logic [31:0] BR_WDATA = 32'h0, BR_RDATA = 32'h0, IC_BUS_DATA = 32'h0;
    logic IC_VALID = 1'b0, IC_DONE, ICP_IN_VALID = 1'b0, ICP_IN_READY;
    logic ICP_FMT_ERROR, ICP_OUT_VALID, ICP_OUT_READY;
    logic [31:0] IC_INSTR, ICP_IN_DATA = 32'h0, ICP_OUT_DATA, r, d;
    logic [2:0] ICP_FORMAT = 3'h0;
    logic [1:0] pace = 2'h2;
    logic [15:0] lf = 16'h003E;
    logic [63:0] e;
    logic se, full_seen = 1'b0;
    int err_count = 0, total_checks = 0, cycles = 0, bad_exp = 0, bad_seen = 0;
    logic [63:0] qd[$];
    logic [31:0] qb[$], qi[$], qp[$];
    localparam logic [31:0] ADR[4] = '{32'h0FFC, 32'h1000, 32'h1FFC, 32'h2000};

    ebls_swapper #(.WIDTH(32), .DEPTH(16)) i_ebls_swapper (.*);
    ebls_pixel_sink i_ebls_pixel_sink (.clk(CLK), .rst(RST), .pace(pace),
        .out_ready(ICP_OUT_READY));

    // Half period of 25 ns gives the 20 MHz clock.
    always #25 CLK = ~CLK;

    function automatic logic [31:0] bsw(logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            rnd[i] = lf[0];
        end
    endfunction
    // Mask in the top half, masked lane or register value below.
    function automatic logic [63:0] dcx(logic bo, w, logic [1:0] sz, k,
        logic [31:0] a, d);
        logic sw;
        logic [4:0] s;
        logic [15:0] h;
        logic [31:0] v, m;
        sw = !bo && (k == 2'h2 || (k == 2'h0 && a >= MEM_BASE && a < MEM_LIMIT));
        s = {a[1:0], 3'h0};
        m = 32'hFFFFFFFF;
        if (sz == 2'h2) begin
            v = sw ? bsw(d) : d;
        end else if (sz == 2'h1) begin
            h = w ? d[15:0] : d[s+:16];
            if (sw) h = {h[7:0], h[15:8]};
            v = w ? {16'h0, h} << s : {16'h0, h};
            if (w) m = 32'h0000FFFF << s;
        end else begin
            v = w ? {24'h0, d[7:0]} << s : {24'h0, d[s+:8]};
            if (w) m = 32'h000000FF << s;
        end
        return {m, v & m};
    endfunction
    task automatic chk(input logic [31:0] x, g);
        total_checks++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask
    task automatic br(input logic w, p, g, s, logic [11:0] a,
        logic [31:0] v, x);
        {BR_VALID, BR_WRITE, BR_FROM_PCI, BR_IS_REG} = {1'b1, w, p, g};
        {BR_IS_SPECIAL, BR_ADDR, BR_WDATA, BR_RDATA} = {s, a, v, v};
        qb.push_back(x);
        @(posedge CLK);
        #1;
    endtask
    task automatic px(input logic [2:0] f, logic [31:0] v);
        logic ok;
        {ICP_IN_VALID, ICP_FORMAT, ICP_IN_DATA} = {1'b1, f, v};
        if (f == 3'h6 && !BYTE_ORDER_SELECT) bad_exp++;
        else if (BYTE_ORDER_SELECT || f < 3'h2) qp.push_back(v);
        else if (f == 3'h2) qp.push_back(bsw(v));
        else qp.push_back({v[23:16], v[31:24], v[7:0], v[15:8]});
        do begin
            ok = ICP_IN_READY;
            @(posedge CLK);
            #1;
        end while (!ok);
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Each result is matched against the oldest note of its stream.
    always @(posedge CLK) begin
        if (!RST && DC_DONE) begin
            e = qd.pop_front();
            chk(e[31:0], (DC_BUS_WDATA | DC_REG_RDATA) & e[63:32]);
        end
        if (!RST && BR_DONE) chk(qb.pop_front(), BR_WDATA_OUT | BR_RDATA_OUT);
        if (!RST && IC_DONE) chk(qi.pop_front(), IC_INSTR);
        if (!RST && ICP_OUT_VALID && ICP_OUT_READY) chk(qp.pop_front(), ICP_OUT_DATA);
        if (!RST && ICP_FMT_ERROR) bad_seen++;
    end
    // A hang ends the run as a failure well past the expected length.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge CLK);
        #1 RST = 1'b0;
        chk(32'h0, 32'(BRIDGE_SWAP_ENABLE));
        // Stores, loads and fetches in both modes around the window edges.
        for (int i = 0; i < 160; i++) begin
            r = rnd();
            d = rnd();
            {BYTE_ORDER_SELECT, DC_VALID, DC_WRITE} = {i[6], 1'b1, r[0]};
            DC_SIZE = 2'(r[3:1] % 3);
            DC_KIND = 2'(r[6:4] % 3);
            DC_ADDR = ADR[r[8:7]] |
                32'(r[10:9] & {~DC_SIZE[1], ~DC_SIZE[1] & ~DC_SIZE[0]});
            {DC_REG_WDATA, DC_BUS_RDATA, IC_BUS_DATA, IC_VALID} = {d, d, d, r[11]};
            qd.push_back(dcx(i[6], r[0], DC_SIZE, DC_KIND, DC_ADDR, d));
            if (r[11]) qi.push_back(d);
            @(posedge CLK);
            #1;
        end
        {DC_VALID, IC_VALID} = 2'h0;
        $display("test data cache done");
        // The host sets swap enable first, with the value pre-swapped.
        br(1'b1, 1'b1, 1'b1, 1'b0, 12'h000, 32'h01000000, 32'h1);
        chk(32'h1, 32'(BRIDGE_SWAP_ENABLE));
        se = 1'b1;
        for (int i = 0; i < 32; i++) begin
            if (i == 16) br(1'b1, 1'b0, 1'b1, 1'b0, 12'h000, 32'h0, 32'h0);
            se = i < 16;
            d = rnd();
            br(i[0], i[1], i[2], i[3], 12'h004, d,
                (i[1] && i[2] && !i[3] && !se) ? bsw(d) : d);
        end
        BR_VALID = 1'b0;
        $display("test bridge done");
        // Stall the sink until the FIFO refuses, then drain it slowly.
        fork
            for (int i = 0; i < 112; i++) begin
                BYTE_ORDER_SELECT = i >= 56;
                px(3'(i % 7), rnd());
            end
            begin
                wait (ICP_IN_READY === 1'b0);
                full_seen = 1'b1;
                repeat (20) @(posedge CLK);
                #1 pace = 2'h1;
            end
        join
        ICP_IN_VALID = 1'b0;
        pace = 2'h0;
        repeat (100) @(posedge CLK);
        chk(32'h1, 32'(full_seen));
        chk(32'(bad_exp), 32'(bad_seen));
        chk(32'h0, 32'(qd.size() + qb.size() + qi.size() + qp.size()));
        $display("test pixel stream done");
        end_sim();
    end
endmodule
`default_nettype wire
